// ### common/lacr_map.svh
// Operation
// - load reading falls linearly, zero at full load
// - stall halts motor without further command
// - max current 0..255 resolved to 32 steps
// - after stop, drop to standby current
// - standstill delay in 10 ms units, default 200
// - minimum select: 0 half, 1 quarter scale
// - down rate picks run 32, 8, 2, 1
// - up step picks increment 1, 2, 4, 8
// - hysteresis spaces lower and upper thresholds
// - stall stop only above stall speed limit
// - adaptive regulation only above enable speed
`ifndef LACR_MAP_SVH
`define LACR_MAP_SVH

// register offsets (word index)
`define LACR_OFS_CTRL 4'h0
`define LACR_OFS_CURRENT 4'h1
`define LACR_OFS_LOAD 4'h2
`define LACR_OFS_SPEED 4'h3
`define LACR_OFS_DELAY 4'h4
`define LACR_OFS_STATUS 4'h5
`define LACR_OFS_IRQ_STATUS 4'h6
`define LACR_OFS_IRQ_MASK 4'h7

// ctrl register fields
`define LACR_CTRL_MINSEL_BIT 0
`define LACR_CTRL_DOWN_LSB 1
`define LACR_CTRL_UP_LSB 3
`define LACR_CTRL_STALL_CLR_BIT 5

// current register fields
`define LACR_CUR_MAX_LSB 0
`define LACR_CUR_STBY_LSB 8

// load register fields
`define LACR_LOAD_LOWER_LSB 0
`define LACR_LOAD_HYST_LSB 16

// speed register fields
`define LACR_SPD_STALL_LSB 0
`define LACR_SPD_ADAPT_LSB 16

// irq bits
`define LACR_IRQ_STALL_BIT 0
`define LACR_IRQ_STANDBY_BIT 1
`define LACR_IRQ_UP_BIT 2
`define LACR_IRQ_DOWN_BIT 3

// reset values
`define LACR_RST_MAX_CURRENT 8'hff
`define LACR_RST_STBY_CURRENT 8'h20
`define LACR_RST_DELAY 16'h00c8
`define LACR_RST_LOWER 10'h040
`define LACR_RST_HYST 10'h040
`define LACR_RST_STALL_SPEED 16'h0000
`define LACR_RST_ADAPT_SPEED 16'h0000

// timing: delay tick in ms, clock in kHz
`define LACR_DELAY_UNIT_MS 10
`define LACR_CLOCK_KHZ 25000
`define LACR_TICK_CYCLES (`LACR_DELAY_UNIT_MS * `LACR_CLOCK_KHZ)

`endif

// ### common/lacr_pkg.sv
`default_nettype none
package lacr_pkg;
    // motor-side state
    typedef enum logic [1:0] {
        LACR_RUN = 2'b00,
        LACR_WAIT = 2'b01,
        LACR_STANDBY = 2'b11,
        LACR_STALLED = 2'b10
    } lacr_state_type;

    // one load sample from the driver
    typedef struct packed {
        logic valid;
        logic [9:0] value;
    } lacr_load_type;

    // register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } lacr_bus_type;
endpackage : lacr_pkg
`default_nettype wire

// ### hdl/lacr_tick.sv
`include "lacr_map.svh"
`default_nettype none
module lacr_tick (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // control
    input wire logic i_clear,
    input wire logic [15:0] i_limit,
    // status
    output logic o_expired
);
    localparam int TICK = `LACR_TICK_CYCLES;
    logic [17:0] pre_q;
    logic [15:0] cnt_q;
    logic tick;
    logic done;

    // 10 ms prescaler feeding the delay counter
    assign tick = (pre_q == 18'(TICK - 1));
    assign done = (cnt_q >= i_limit);
    assign o_expired = done;

    // prescaler and unit counter, saturate once the delay has run out
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_q <= 18'h0_0000;
            cnt_q <= 16'h0000;
        end else if (i_ce) begin
            if (i_clear) begin
                pre_q <= 18'h0_0000;
                cnt_q <= 16'h0000;
            end else if (!done) begin
                pre_q <= tick ? 18'h0_0000 : pre_q + 18'h0_0001;
                if (tick) begin
                    cnt_q <= cnt_q + 16'h0001;
                end
            end
        end
    end
endmodule : lacr_tick
`default_nettype wire

// ### hdl/lacr_regulator.sv
// Implementation choices: the plain strobed port and the address map.
`include "lacr_map.svh"
`default_nettype none
module lacr_regulator (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // load reading from the driver (same clock)
    input wire logic i_load_valid,
    input wire logic [9:0] i_load,
    // motion state
    input wire logic [15:0] i_speed,
    // motor control
    output logic [7:0] o_current,
    output logic o_stall_stop,
    output logic o_standby,
    // interrupt
    output logic o_irq
);
    // bus and load carriers, motor state
    lacr_pkg::lacr_bus_type bus;
    lacr_pkg::lacr_load_type load;
    lacr_pkg::lacr_state_type state_q;
    lacr_pkg::lacr_state_type state_d;

    // configuration registers
    logic min_current_select_q;
    logic [1:0] current_down_rate_q;
    logic [1:0] current_up_step_q;
    logic [7:0] max_current_setting_q;
    logic [7:0] standby_current_setting_q;
    logic [9:0] lower_q;
    logic [9:0] load_hysteresis_q;
    logic [15:0] stall_stop_speed_q;
    logic [15:0] adaptive_enable_speed_q;
    logic [15:0] standstill_delay_q;
    logic [3:0] irq_status_q;
    logic [3:0] irq_mask_q;
    logic [31:0] rdata_q;

    // regulation state
    logic [7:0] adapt_q;
    logic [4:0] down_cnt_q;
    logic [7:0] current_q;

    assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
    assign load = '{valid: i_load_valid, value: i_load};

    // address decode, used by write and read paths
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // down run length per rate code, one short since the count starts at zero
    function automatic logic [4:0] run_of(input logic [1:0] code);
        unique case (code)
            2'h0: run_of = 5'h1f;
            2'h1: run_of = 5'h07;
            2'h2: run_of = 5'h01;
            2'h3: run_of = 5'h00;
        endcase
    endfunction : run_of

    // up increment per step code
    function automatic logic [3:0] inc_of(input logic [1:0] code);
        unique case (code)
            2'h0: inc_of = 4'h1;
            2'h1: inc_of = 4'h2;
            2'h2: inc_of = 4'h4;
            2'h3: inc_of = 4'h8;
        endcase
    endfunction : inc_of

    // per-register strobes, all qualified by the write or read strobe
    logic wr_ctrl, wr_cur, wr_load, wr_spd, wr_delay, wr_mask, rd_irq;
    assign wr_ctrl = bus.wr && hit(bus.addr, `LACR_OFS_CTRL);
    assign wr_cur = bus.wr && hit(bus.addr, `LACR_OFS_CURRENT);
    assign wr_load = bus.wr && hit(bus.addr, `LACR_OFS_LOAD);
    assign wr_spd = bus.wr && hit(bus.addr, `LACR_OFS_SPEED);
    assign wr_delay = bus.wr && hit(bus.addr, `LACR_OFS_DELAY);
    assign wr_mask = bus.wr && hit(bus.addr, `LACR_OFS_IRQ_MASK);
    assign rd_irq = bus.rd && hit(bus.addr, `LACR_OFS_IRQ_STATUS);

    // leaving stall takes an explicit write, never a timeout
    logic stall_clear;
    assign stall_clear = wr_ctrl && bus.wdata[`LACR_CTRL_STALL_CLR_BIT];

    // thresholds: upper sits hysteresis above lower
    logic [10:0] upper;
    logic below_lower, above_upper;
    assign upper = {1'b0, lower_q} + {1'b0, load_hysteresis_q};
    assign below_lower = load.valid && (load.value < lower_q);
    assign above_upper = load.valid && ({1'b0, load.value} > upper);

    // speed gates; reading is zero at full load so zero means stall
    logic moving, adaptive_on, stall_event;
    assign moving = (i_speed != 16'h0000);
    assign adaptive_on = (i_speed > adaptive_enable_speed_q);
    assign stall_event = load.valid && (load.value == 10'h000)
        && (i_speed > stall_stop_speed_q);

    // limits: run ceiling is the 32-step grid, floor a fraction of it
    logic [7:0] ceiling, floor_cur;
    assign ceiling = {max_current_setting_q[7:3], 3'b111};
    assign floor_cur = min_current_select_q ? {2'b00, ceiling[7:2]}
        : {1'b0, ceiling[7:1]};

    // down run length and up increment decode
    logic [4:0] run_len;
    logic [3:0] up_inc;
    assign run_len = run_of(current_down_rate_q);
    assign up_inc = inc_of(current_up_step_q);

    // saturating adjust arithmetic
    logic [8:0] up_sum;
    logic [7:0] up_val, down_val;
    logic do_down;
    assign up_sum = {1'b0, adapt_q} + {5'h00, up_inc};
    assign up_val = (up_sum > {1'b0, ceiling}) ? ceiling : up_sum[7:0];
    assign do_down = above_upper && (down_cnt_q == run_len);
    assign down_val = (adapt_q > floor_cur) ? adapt_q - 8'h01 : floor_cur;

    // standstill delay timer
    logic delay_done;
    lacr_tick u_tick (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_clear(moving),
        .i_limit(standstill_delay_q),
        .o_expired(delay_done)
    );

    // motor state machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            lacr_pkg::LACR_RUN: begin
                if (stall_event) begin
                    state_d = lacr_pkg::LACR_STALLED;
                end else if (!moving) begin
                    state_d = lacr_pkg::LACR_WAIT;
                end
            end
            lacr_pkg::LACR_WAIT: begin
                // motion before the delay runs out skips standby
                if (moving) begin
                    state_d = lacr_pkg::LACR_RUN;
                end else if (delay_done) begin
                    state_d = lacr_pkg::LACR_STANDBY;
                end
            end
            lacr_pkg::LACR_STANDBY: begin
                if (moving) begin
                    state_d = lacr_pkg::LACR_RUN;
                end
            end
            lacr_pkg::LACR_STALLED: begin
                // motion alone never leaves stall
                if (stall_clear) begin
                    state_d = lacr_pkg::LACR_RUN;
                end
            end
        endcase
    end

    // output current selection
    logic [7:0] current_d;
    assign current_d = (state_q == lacr_pkg::LACR_STANDBY) ? standby_current_setting_q
        : adaptive_on ? adapt_q : ceiling;

    // hardware events for the sticky status
    logic [3:0] events;
    assign events[`LACR_IRQ_STALL_BIT] = (state_d == lacr_pkg::LACR_STALLED)
        && (state_q != lacr_pkg::LACR_STALLED);
    assign events[`LACR_IRQ_STANDBY_BIT] = (state_d == lacr_pkg::LACR_STANDBY)
        && (state_q != lacr_pkg::LACR_STANDBY);

    // adaptive steps count only inside the enable band
    assign events[`LACR_IRQ_UP_BIT] = adaptive_on && below_lower;
    assign events[`LACR_IRQ_DOWN_BIT] = adaptive_on && do_down;

    // read mux
    logic [31:0] rd_mux;
    assign rd_mux = hit(bus.addr, `LACR_OFS_CTRL) ? {27'h000_0000, current_up_step_q,
            current_down_rate_q, min_current_select_q} :
        hit(bus.addr, `LACR_OFS_CURRENT) ? {16'h0000, standby_current_setting_q,
            max_current_setting_q} :
        hit(bus.addr, `LACR_OFS_LOAD) ? {6'h00, load_hysteresis_q, 6'h00, lower_q} :
        hit(bus.addr, `LACR_OFS_SPEED) ? {adaptive_enable_speed_q, stall_stop_speed_q} :
        hit(bus.addr, `LACR_OFS_DELAY) ? {16'h0000, standstill_delay_q} :
        hit(bus.addr, `LACR_OFS_STATUS) ? {14'h0000, state_q, 8'h00, current_q} :
        hit(bus.addr, `LACR_OFS_IRQ_STATUS) ? {28'h000_0000, irq_status_q} :
        hit(bus.addr, `LACR_OFS_IRQ_MASK) ? {28'h000_0000, irq_mask_q} : 32'h0000_0000;

    // configuration writes
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            min_current_select_q <= 1'b0;
            current_down_rate_q <= 2'd0;
            current_up_step_q <= 2'd0;
            max_current_setting_q <= `LACR_RST_MAX_CURRENT;
            standby_current_setting_q <= `LACR_RST_STBY_CURRENT;
            lower_q <= `LACR_RST_LOWER;
            load_hysteresis_q <= `LACR_RST_HYST;
            stall_stop_speed_q <= `LACR_RST_STALL_SPEED;
            adaptive_enable_speed_q <= `LACR_RST_ADAPT_SPEED;
            standstill_delay_q <= `LACR_RST_DELAY;
            irq_mask_q <= 4'h0;
        end else if (i_ce) begin
            if (wr_ctrl) begin
                min_current_select_q <= bus.wdata[`LACR_CTRL_MINSEL_BIT];
                current_down_rate_q <= bus.wdata[`LACR_CTRL_DOWN_LSB +: 2];
                current_up_step_q <= bus.wdata[`LACR_CTRL_UP_LSB +: 2];
            end
            if (wr_cur) begin
                max_current_setting_q <= bus.wdata[`LACR_CUR_MAX_LSB +: 8];
                standby_current_setting_q <= bus.wdata[`LACR_CUR_STBY_LSB +: 8];
            end
            if (wr_load) begin
                lower_q <= bus.wdata[`LACR_LOAD_LOWER_LSB +: 10];
                load_hysteresis_q <= bus.wdata[`LACR_LOAD_HYST_LSB +: 10];
            end
            if (wr_spd) begin
                stall_stop_speed_q <= bus.wdata[`LACR_SPD_STALL_LSB +: 16];
                adaptive_enable_speed_q <= bus.wdata[`LACR_SPD_ADAPT_LSB +: 16];
            end
            if (wr_delay) begin
                standstill_delay_q <= bus.wdata[15:0];
            end
            if (wr_mask) begin
                irq_mask_q <= bus.wdata[3:0];
            end
        end
    end

    // read data: one cycle slot, zero otherwise
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (i_ce) begin
            rdata_q <= bus.rd ? rd_mux : 32'h0000_0000;
        end
    end

    // sticky status per event bit; a new event wins over read clear
    for (genvar g = 0; g < 4; g++) begin : g_sticky
        always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
                irq_status_q[g] <= 1'b0;
            end else if (i_ce) begin
                irq_status_q[g] <= events[g] || (irq_status_q[g] && !rd_irq);
            end
        end
    end

    // adaptive current: step up per low reading, down after a run of high ones
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            adapt_q <= `LACR_RST_MAX_CURRENT;
            down_cnt_q <= 5'd0;
        end else if (i_ce) begin
            if (!adaptive_on) begin
                adapt_q <= ceiling; // restart from run current
                down_cnt_q <= 5'd0;
            end else if (below_lower) begin
                adapt_q <= up_val;
                down_cnt_q <= 5'd0;
            end else if (above_upper) begin
                down_cnt_q <= do_down ? 5'd0 : down_cnt_q + 5'd1;
                if (do_down) begin
                    adapt_q <= down_val;
                end
            end else if (adapt_q > ceiling) begin
                adapt_q <= ceiling; // follow a lowered setting
            end
        end
    end

    // motor state and registered current
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= lacr_pkg::LACR_RUN;
            current_q <= 8'h00;
        end else if (i_ce) begin
            state_q <= state_d;
            current_q <= current_d;
        end
    end

    // outputs
    assign o_rdata = rdata_q;
    assign o_current = current_q;
    assign o_stall_stop = (state_q == lacr_pkg::LACR_STALLED);
    assign o_standby = (state_q == lacr_pkg::LACR_STANDBY);
    assign o_irq = |(irq_status_q & irq_mask_q);
endmodule : lacr_regulator
`default_nettype wire

// ### test/lacr_load_model.sv
`default_nettype none
module lacr_load_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // request from the bench
    input wire logic i_send,
    input wire logic [9:0] i_force,
    // load reading toward the regulator
    output logic o_valid,
    output logic [9:0] o_load
);
    // reading falls as mechanical load rises, zero at full load; after the
    // strobe the line flips so a stale value is never mistaken for a sample
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
            o_load <= 10'h155;
        end else begin
            o_valid <= i_send;
            o_load <= i_send ? 10'h3ff - i_force : ~o_load;
        end
    end
endmodule : lacr_load_model
`default_nettype wire

// ### test/lacr_regulator_checker.sv
`default_nettype none
module lacr_regulator_checker (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // load and motion
    input wire logic i_load_valid,
    input wire logic [9:0] i_load,
    input wire logic [15:0] i_speed,
    // motor control
    input wire logic [7:0] o_current,
    input wire logic o_stall_stop,
    input wire logic o_standby,
    input wire logic o_irq
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic [15:0] spd_q;
    logic [2:0] calm_q;
    wire calm = (&calm_q) && (i_speed == spd_q) && !o_standby && !o_stall_stop;
    // quiet history: writes and speed moves also shift current, so skip them
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            spd_q <= 16'h0000;
            calm_q <= 3'h0;
        end else begin
            spd_q <= i_speed;
            calm_q <= {calm_q[1:0], (i_speed == spd_q) && !i_wr && !o_standby && !o_stall_stop};
        end
    end
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
        else $error("read data outside read slot");
    stall_cause_a: assert property ($rose(o_stall_stop) |->
        $past(i_load_valid) && $past(i_load) == 10'h000) else $error("stall without zero load");
    stall_speed_a: assert property (i_load_valid && i_load == 10'h000 &&
        i_speed == 16'h0000 && !o_stall_stop |=> !o_stall_stop) else $error("stall at standstill");
    stall_hold_a: assert property ($fell(o_stall_stop) |->
        $past(i_wr && i_addr == 4'h0 && i_wdata[5]) ||
        $past(i_wr && i_addr == 4'h0 && i_wdata[5], 2)) else $error("stall left by itself");
    standby_entry_a: assert property ($rose(o_standby) |-> $past(i_speed) == 16'h0000)
        else $error("standby while moving");
    standby_exit_a: assert property ($past(o_standby) && $past(i_speed) != 16'h0000 |->
        !o_standby) else $error("standby kept while moving");
    adapt_cause_a: assert property (calm && o_current != $past(o_current) |->
        $past(i_load_valid, 2)) else $error("current moved without sample");
    up_step_a: assert property (calm && o_current > $past(o_current) |->
        o_current - $past(o_current) <= 8'h08) else $error("increment too large");
    down_step_a: assert property (calm && o_current < $past(o_current) |->
        $past(o_current) - o_current == 8'h01) else $error("decrement not one");
endmodule : lacr_regulator_checker
bind lacr_regulator lacr_regulator_checker u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_load_valid(i_load_valid), .i_load(i_load), .i_speed(i_speed),
    .o_current(o_current), .o_stall_stop(o_stall_stop), .o_standby(o_standby), .o_irq(o_irq));
`default_nettype wire

// ### test/lacr_regulator_tb.sv
`default_nettype none
module lacr_regulator_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [15:0] i_speed = 16'h0064;
    logic send = 1'b0;
    logic [9:0] load_force = 10'h000;
    logic i_load_valid;
    logic [9:0] i_load;
    logic [31:0] o_rdata;
    logic [7:0] o_current;
    logic o_stall_stop;
    logic o_standby;
    logic o_irq;
    logic [7:0] cur;
    logic ce = 1'b1;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int run [4] = '{32, 8, 2, 1};
    // hi reads 0x200, above lower plus hysteresis; lo reads 0x010; full reads 0
    localparam logic [9:0] HI = 10'h1ff;
    localparam logic [9:0] LO = 10'h3ef;
    localparam logic [9:0] FULL = 10'h3ff;
    lacr_regulator u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ce(ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_load_valid(i_load_valid), .i_load(i_load), .i_speed(i_speed),
        .o_current(o_current), .o_stall_stop(o_stall_stop), .o_standby(o_standby),
        .o_irq(o_irq));
    lacr_load_model u_drv (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_send(send),
        .i_force(load_force), .o_valid(i_load_valid), .o_load(i_load));
    initial begin
        forever #20 i_clock = ~i_clock;
    end
    task conclude;
        if (err_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    // hang guard, well above the longest scenario
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk(o_rdata & m, e);
    endtask : rd
    // n back-to-back samples, then wait out the two-cycle answer
    task smp(input logic [9:0] f, input int n);
        @(posedge i_clock);
        send <= 1'b1;
        load_force <= f;
        repeat (n) @(posedge i_clock);
        send <= 1'b0;
        repeat (4) @(posedge i_clock);
        #1;
    endtask : smp
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd(4'h1, 32'h0000_20ff);
        rd(4'h2, 32'h0040_0040);
        rd(4'h3, 32'h0000_0000);
        rd(4'h4, 32'h0000_00c8);
        rd(4'h7, 32'h0000_0000);
        rd(4'h8, 32'h0000_0000);
        rd(4'h5, 32'h0000_00ff);
        // odd setting snaps to its step; speed below both limits
        wr(4'h1, 32'h0000_378a);
        wr(4'h3, 32'h00c8_00c8);
        smp(LO, 3);
        chk(32'(o_current), 32'h0000_008f);
        smp(FULL, 1);
        chk(32'(o_stall_stop), 32'h0000_0000);
        wr(4'h1, 32'h0000_37ff);
        wr(4'h3, 32'h0032_00c8);
        cur = 8'hff;
        // each down rate: one short of the run holds, the last sample steps
        for (int r = 0; r < 4; r++) begin
            wr(4'h0, 32'(r) << 1);
            if (run[r] > 1) smp(HI, run[r] - 1);
            chk(32'(o_current), 32'(cur));
            smp(HI, 1);
            cur = cur - 8'h01;
            chk(32'(o_current), 32'(cur));
        end
        // each up step, saturating at the ceiling
        for (int u = 0; u < 4; u++) begin
            wr(4'h0, 32'(u) << 3);
            smp(LO, 1);
            cur = ((cur + (8'h01 << u)) > 8'hff || (cur + (8'h01 << u)) < cur) ? 8'hff :
                cur + (8'h01 << u);
            chk(32'(o_current), 32'(cur));
        end
        wr(4'h0, 32'h0000_0006);
        smp(HI, 140);
        chk(32'(o_current), 32'h0000_007f);
        wr(4'h0, 32'h0000_0007);
        smp(HI, 70);
        chk(32'(o_current), 32'h0000_003f);
        // enable low freezes regulation: a low reading is ignored
        @(posedge i_clock);
        ce <= 1'b0;
        smp(LO, 1);
        @(posedge i_clock);
        ce <= 1'b1;
        #1 chk(32'(o_current), 32'h0000_003f);
        // stall above the speed limit, then software release
        rd(4'h6, 32'h0000_000c);
        wr(4'h7, 32'h0000_0001);
        wr(4'h3, 32'h0032_0032);
        smp(FULL, 1);
        chk(32'(o_stall_stop), 32'h0000_0001);
        chk(32'(o_irq), 32'h0000_0001);
        rd(4'h6, 32'h0000_0001, 32'h0000_0001);
        chk(32'(o_irq), 32'h0000_0000);
        wr(4'h0, 32'h0000_0020);
        repeat (2) @(posedge i_clock);
        #1 chk(32'(o_stall_stop), 32'h0000_0000);
        // zero delay keeps the standby wait short
        wr(4'h4, 32'h0000_0000);
        wr(4'h7, 32'h0000_0002);
        @(posedge i_clock);
        i_speed <= 16'h0000;
        for (int k = 0; k < 50 && o_standby !== 1'b1; k++) @(posedge i_clock) #1;
        repeat (3) @(posedge i_clock);
        #1 chk(32'(o_current), 32'h0000_0037);
        chk(32'(o_irq), 32'h0000_0001);
        // full load at standstill must not stop the motor
        smp(FULL, 1);
        chk(32'(o_stall_stop), 32'h0000_0000);
        rd(4'h5, 32'h0003_0037);
        @(posedge i_clock);
        i_speed <= 16'h0064;
        repeat (3) @(posedge i_clock);
        #1 chk(32'(o_standby), 32'h0000_0000);
        conclude();
    end
endmodule : lacr_regulator_tb
`default_nettype wire
